// ==== hw/setpt_map_pkg.sv ====
// Constants, encodings and register map for the analog set-point mapper
package setpt_map_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int ADC_W = 12;
  localparam int VAL_W = 16;
  localparam int NCH = 4;
  localparam int NPAR = 6;
  localparam int ASG_W = 3;
  localparam int FAST_CH = 1;
  localparam int FILT_SHIFT = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 100;
  localparam int FAST_PERIOD_US = 500;
  localparam int FAST_PERIOD_CYC = FAST_PERIOD_US * CLK_FREQ_MHZ;
  localparam int FAST_CNT_W = 17;

  // ****************************************
  // Set-point sources and parameter codes
  // ****************************************
  typedef enum logic [1:0] {
    SRC_FRONT = 2'b00,
    SRC_FGEN = 2'b01,
    SRC_ANALOG = 2'b10,
    SRC_SEQ = 2'b11
  } src_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  localparam logic [ASG_W-1:0] ASG_NONE = 3'h0;
  localparam logic [ASG_W-1:0] ASG_MAX = 3'h6;
  localparam int P_VSET = 0;
  localparam int P_ISET = 1;
  localparam int P_PSET = 2;
  localparam int P_OV_TRIP = 3;
  localparam int P_OC_TRIP = 4;
  localparam int P_OP_TRIP = 5;
  localparam int P_FIRST_TRIP = 3;

  // ****************************************
  // Scaling, in output code units; ADC full scale in ADC codes
  // ****************************************
  localparam logic [VAL_W-1:0] PCT10 = 16'h0FA0;
  localparam logic [VAL_W-1:0] PCT100 = 16'h9C40;
  localparam logic [VAL_W-1:0] PCT110 = 16'hABE0;
  localparam logic [ADC_W-1:0] ADC_FULL_DEF = 12'hFFF;

  // ****************************************
  // Register map (byte offsets) and reset values
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ASSIGN = 8'h04;
  localparam logic [7:0] OFS_STORED0 = 8'h08;
  localparam logic [7:0] OFS_EFF0 = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_HIT_LSB = 8;
  localparam int ASG_FIELD_STEP = 4;
  localparam src_t SRC_RST = SRC_FRONT;
  localparam logic [VAL_W-1:0] STORED_RST = 16'h0000;

endpackage

// ==== hw/heavy_lowpass.sv ====
// First-order heavy low-pass filter for one standard analog channel
`timescale 1ns/1ps
module heavy_lowpass #(
  parameter int W = 12,
  parameter int SHIFT = 6
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic valid_i,
  input wire logic [W-1:0] x_i,
  output logic [W-1:0] y_o
);

  // ****************************************
  // Accumulator
  // ****************************************
  // Accumulator keeps SHIFT extra bits so small steps are not lost
  logic [W+SHIFT-1:0] acc_reg;
  logic [W+SHIFT-1:0] acc_next;

  always_comb begin
    acc_next = acc_reg - (acc_reg >> SHIFT) + (W+SHIFT)'(x_i);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      acc_reg <= '0;
    end else if (valid_i) begin
      acc_reg <= acc_next;
    end
  end

  assign y_o = acc_reg[W+SHIFT-1:SHIFT];

  // ****************************************
  // Checks
  // ****************************************
  property p_filt_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !valid_i |=> $stable(acc_reg);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("Filter moved without a sample");

endmodule

// ==== hw/analog_setpoint_input_mapper.sv ====
// Analog input to set-point and trip-level mapper with Avalon-MM registers
`timescale 1ns/1ps
module analog_setpoint_input_mapper
  import setpt_map_pkg::*;
#(
  parameter int FAST_PERIOD = FAST_PERIOD_CYC,
  parameter logic [ADC_W-1:0] ADC_FULL = ADC_FULL_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic factory_restore_i,
  input wire logic [NCH-1:0] ain_valid_i,
  input wire logic [NCH-1:0] ain_present_i,
  input wire logic [NCH*ADC_W-1:0] ain_code_i,
  input wire logic [VAL_W-1:0] fgen_iset_i,
  input wire logic [3*VAL_W-1:0] seq_setpt_i,
  output logic [VAL_W-1:0] vset_o,
  output logic [VAL_W-1:0] iset_o,
  output logic [VAL_W-1:0] pset_o,
  output logic [VAL_W-1:0] overvoltage_trip_level_o,
  output logic [VAL_W-1:0] overcurrent_trip_level_o,
  output logic [VAL_W-1:0] overpower_trip_level_o
);

  // ****************************************
  // Declarations
  // ****************************************
  bus_state_t bus_state_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic [5:0] idx;
  logic wr_en;
  logic [31:0] wmask;
  src_t src_reg;
  logic [ASG_W-1:0] asg_reg [NCH];
  logic [VAL_W-1:0] stored_reg [NPAR];
  logic [VAL_W-1:0] eff_reg [NPAR];
  logic [VAL_W-1:0] eff_next [NPAR];
  logic [ADC_W-1:0] raw_reg [NCH];
  logic [ADC_W-1:0] chan_val [NCH];
  logic [ADC_W-1:0] fast_hold_reg;
  logic [FAST_CNT_W-1:0] fast_cnt_reg;
  logic fast_tick_reg;
  logic [NPAR-1:0] hit;
  logic [VAL_W-1:0] ana_val [NPAR];

  // ****************************************
  // Scaling
  // ****************************************
  // Division by a constant; folds to a multiplier in synthesis
  function automatic logic [VAL_W-1:0] scale_code(input logic [ADC_W-1:0] code,
                                                  input logic trip);
    logic [ADC_W-1:0] sat;
    logic [31:0] prod;
    logic [31:0] q;
    sat = (code > ADC_FULL) ? ADC_FULL : code;
    prod = 32'(sat) * 32'(PCT100);
    q = prod / 32'(ADC_FULL);
    if (trip) begin
      q = q + 32'(PCT10);
    end
    return q[VAL_W-1:0];
  endfunction

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  assign idx = address_i[7:2];
  assign wr_en = write_i && (bus_state_reg == BUS_ACK);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{byteenable_i[b]}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (read_i || write_i) begin
            bus_state_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_state_reg <= BUS_IDLE;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // One wait cycle per access, then a single-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((bus_state_reg == BUS_IDLE) && (read_i || write_i));
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (address_i == OFS_CTRL) begin
      rd_mux = 32'(src_reg);
    end else if (address_i == OFS_ASSIGN) begin
      for (int c = 0; c < NCH; c++) begin
        rd_mux[c*ASG_FIELD_STEP +: ASG_W] = asg_reg[c];
      end
    end else if (address_i == OFS_STATUS) begin
      rd_mux[STAT_ACTIVE_BIT] = (src_reg == SRC_ANALOG);
      rd_mux[STAT_HIT_LSB +: NPAR] = hit;
    end else begin
      for (int p = 0; p < NPAR; p++) begin
        if (idx == 6'(OFS_STORED0[7:2] + 6'(p))) begin
          rd_mux = 32'(stored_reg[p]);
        end
        if (idx == 6'(OFS_EFF0[7:2] + 6'(p))) begin
          rd_mux = 32'(eff_reg[p]);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if ((bus_state_reg == BUS_IDLE) && read_i) begin
      rdata_reg <= rd_mux;
    end
  end

  assign readdata_o = rdata_reg;
  assign waitrequest_o = wait_reg;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i || factory_restore_i) begin
      src_reg <= SRC_RST;
    end else if (wr_en && address_i == OFS_CTRL && byteenable_i[0]) begin
      src_reg <= src_t'(writedata_i[1:0]);
    end
  end

  // Codes beyond the last parameter fall back to unassigned
  always_ff @(posedge clk_i) begin
    if (!rstn_i || factory_restore_i) begin
      for (int c = 0; c < NCH; c++) begin
        asg_reg[c] <= ASG_NONE;
      end
    end else if (wr_en && address_i == OFS_ASSIGN) begin
      for (int c = 0; c < NCH; c++) begin
        if (byteenable_i[(c*ASG_FIELD_STEP)/8]) begin
          if (writedata_i[c*ASG_FIELD_STEP +: ASG_W] > ASG_MAX) begin
            asg_reg[c] <= ASG_NONE;
          end else begin
            asg_reg[c] <= writedata_i[c*ASG_FIELD_STEP +: ASG_W];
          end
        end
      end
    end
  end

  // Stored values still take writes; they return once unassigned
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < NPAR; p++) begin
        stored_reg[p] <= STORED_RST;
      end
    end else if (wr_en) begin
      for (int p = 0; p < NPAR; p++) begin
        if (idx == 6'(OFS_STORED0[7:2] + 6'(p))) begin
          stored_reg[p] <= (stored_reg[p] & ~wmask[VAL_W-1:0])
                           | (writedata_i[VAL_W-1:0] & wmask[VAL_W-1:0]);
        end
      end
    end
  end

  // ****************************************
  // Channel sampling and filtering
  // ****************************************
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          raw_reg[gc] <= '0;
        end else if (ain_valid_i[gc]) begin
          raw_reg[gc] <= ain_present_i[gc] ? ain_code_i[gc*ADC_W +: ADC_W] : '0;
        end
      end
      if (gc == FAST_CH) begin : g_fast
        assign chan_val[gc] = fast_hold_reg;
      end else begin : g_std
        heavy_lowpass #(
          .W(ADC_W),
          .SHIFT(FILT_SHIFT)
        ) u_filt (
          .clk_i(clk_i),
          .rstn_i(rstn_i),
          .valid_i(ain_valid_i[gc]),
          .x_i(ain_present_i[gc] ? ain_code_i[gc*ADC_W +: ADC_W] : '0),
          .y_o(chan_val[gc])
        );
      end
    end
  endgenerate

  // ****************************************
  // Fast channel refresh
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fast_cnt_reg <= '0;
      fast_tick_reg <= 1'b0;
    end else if (fast_cnt_reg == FAST_CNT_W'(FAST_PERIOD - 1)) begin
      fast_cnt_reg <= '0;
      fast_tick_reg <= 1'b1;
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 1'b1;
      fast_tick_reg <= 1'b0;
    end
  end

  // Unfiltered; holds between ticks so the controller sees a fixed rate
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fast_hold_reg <= '0;
    end else if (fast_tick_reg) begin
      fast_hold_reg <= raw_reg[FAST_CH];
    end
  end

  // ****************************************
  // Parameter selection
  // ****************************************
  // Lowest-numbered channel wins when two share a parameter
  always_comb begin
    for (int p = 0; p < NPAR; p++) begin
      hit[p] = 1'b0;
      ana_val[p] = '0;
      for (int c = NCH - 1; c >= 0; c--) begin
        if (asg_reg[c] == ASG_W'(p + 1)) begin
          hit[p] = 1'b1;
          ana_val[p] = scale_code(chan_val[c], p >= P_FIRST_TRIP);
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NPAR; p++) begin
      case (src_reg)
        SRC_ANALOG: begin
          eff_next[p] = hit[p] ? ana_val[p] : stored_reg[p];
        end
        SRC_FGEN: begin
          eff_next[p] = (p == P_ISET) ? fgen_iset_i : stored_reg[p];
        end
        SRC_SEQ: begin
          eff_next[p] = (p < P_FIRST_TRIP) ? seq_setpt_i[(p % P_FIRST_TRIP)*VAL_W +: VAL_W]
                                           : stored_reg[p];
        end
        default: begin
          eff_next[p] = stored_reg[p];
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < NPAR; p++) begin
        eff_reg[p] <= STORED_RST;
      end
    end else begin
      for (int p = 0; p < NPAR; p++) begin
        eff_reg[p] <= eff_next[p];
      end
    end
  end

  assign vset_o = eff_reg[P_VSET];
  assign iset_o = eff_reg[P_ISET];
  assign pset_o = eff_reg[P_PSET];
  assign overvoltage_trip_level_o = eff_reg[P_OV_TRIP];
  assign overcurrent_trip_level_o = eff_reg[P_OC_TRIP];
  assign overpower_trip_level_o = eff_reg[P_OP_TRIP];

  // ****************************************
  // Checks
  // ****************************************
  property p_asg_range;
    @(posedge clk_i) disable iff (!rstn_i)
    (asg_reg[0] <= ASG_MAX) && (asg_reg[1] <= ASG_MAX)
    && (asg_reg[2] <= ASG_MAX) && (asg_reg[3] <= ASG_MAX);
  endproperty
  a_asg_range: assert property (p_asg_range) else $error("Bad channel assignment");

  property p_local_ignores_analog;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg == SRC_FRONT) |=> (vset_o == $past(stored_reg[P_VSET]))
                               && (overcurrent_trip_level_o == $past(stored_reg[P_OC_TRIP]));
  endproperty
  a_local_ignores_analog: assert property (p_local_ignores_analog) else $error("Analog leak");

  property p_restore_default;
    @(posedge clk_i) disable iff (!rstn_i)
    factory_restore_i |=> (src_reg == SRC_FRONT) && (asg_reg[0] == ASG_NONE);
  endproperty
  a_restore_default: assert property (p_restore_default) else $error("Restore kept analog");

  property p_floating_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    (ain_valid_i[FAST_CH] && !ain_present_i[FAST_CH]) |=> (raw_reg[FAST_CH] == '0);
  endproperty
  a_floating_zero: assert property (p_floating_zero) else $error("Floating input not zero");

  sequence s_tick;
    fast_tick_reg;
  endsequence
  sequence s_quiet;
    !fast_tick_reg [*4];
  endsequence
  property p_fast_spacing;
    @(posedge clk_i) disable iff (!rstn_i)
    s_tick |=> s_quiet;
  endproperty
  a_fast_spacing: assert property (p_fast_spacing) else $error("Fast refresh too soon");

  property p_fast_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !fast_tick_reg |=> $stable(fast_hold_reg);
  endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("Fast value moved off tick");

  property p_setpt_full;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg == SRC_ANALOG) && (asg_reg[0] == ASG_W'(P_VSET + 1))
    && (chan_val[0] >= ADC_FULL) |=> (vset_o == PCT100);
  endproperty
  a_setpt_full: assert property (p_setpt_full) else $error("Set point not 100 percent");

  property p_trip_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg == SRC_ANALOG) && (asg_reg[0] == ASG_W'(P_OV_TRIP + 1))
    && (chan_val[0] == '0) |=> (overvoltage_trip_level_o == PCT10);
  endproperty
  a_trip_zero: assert property (p_trip_zero) else $error("Trip floor not 10 percent");

  property p_stored_ignored;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg == SRC_ANALOG) && hit[P_ISET] |=> (iset_o == $past(ana_val[P_ISET]));
  endproperty
  a_stored_ignored: assert property (p_stored_ignored) else $error("Stored value used");

  property p_readback;
    @(posedge clk_i) disable iff (!rstn_i)
    (bus_state_reg == BUS_IDLE) && read_i && (address_i == OFS_EFF0)
    |=> (readdata_o == 32'($past(eff_reg[P_VSET]))) && !waitrequest_o;
  endproperty
  a_readback: assert property (p_readback) else $error("Readback mismatch");

  property p_fgen_route;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg == SRC_FGEN) |=> (iset_o == $past(fgen_iset_i))
                              && (vset_o == $past(stored_reg[P_VSET]));
  endproperty
  a_fgen_route: assert property (p_fgen_route) else $error("Wrong source routed");

  property p_trip_ceiling;
    @(posedge clk_i) disable iff (!rstn_i)
    (src_reg == SRC_ANALOG) && hit[P_OP_TRIP] |=> (overpower_trip_level_o <= PCT110);
  endproperty
  a_trip_ceiling: assert property (p_trip_ceiling) else $error("Trip above 110 percent");

endmodule

// ==== tb/adc_sampler_model.sv ====
// Behavioural analog sampler driving the mapper's four channel inputs
`timescale 1ns/1ps
module adc_sampler_model
  import setpt_map_pkg::*;
(
  input wire logic clk_i,
  output logic [NCH-1:0] ain_valid_o,
  output logic [NCH-1:0] ain_present_o,
  output logic [NCH*ADC_W-1:0] ain_code_o
);
  initial begin
    ain_valid_o = '0;
    ain_present_o = '1;
    ain_code_o = '0;
  end

  // ****************************************
  // One sample strobe
  // ****************************************
  // Code lines are inverted after the strobe, so a late capture reads wrong data
  task automatic sample(input int ch, input logic [ADC_W-1:0] code, input logic present);
    @(posedge clk_i);
    ain_present_o[ch] <= present;
    ain_code_o[ch*ADC_W +: ADC_W] <= code;
    ain_valid_o[ch] <= 1'b1;
    @(posedge clk_i);
    ain_valid_o[ch] <= 1'b0;
    ain_code_o[ch*ADC_W +: ADC_W] <= ~code;
  endtask
endmodule

// ==== tb/test_analog_setpoint_input_mapper.sv ====
// Self-checking bench for the analog set-point mapper
`timescale 1ns/1ps
module test_analog_setpoint_input_mapper;
  import setpt_map_pkg::*;
  // Short refresh period keeps the run brief
  localparam int FP = 20;
  localparam logic [ADC_W-1:0] AF = 12'hF00;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'hF;
  logic factory_restore_i = 1'b0;
  logic [VAL_W-1:0] fgen_iset_i = 16'h0;
  logic [3*VAL_W-1:0] seq_setpt_i = 48'h0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic [NCH-1:0] ain_valid;
  logic [NCH-1:0] ain_present;
  logic [NCH*ADC_W-1:0] ain_code;
  logic [5:0][VAL_W-1:0] outs;
  logic [ADC_W-1:0] codes [5];
  logic [31:0] rd;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 27;
  int stored [6];
  int acc [4];
  int x;
  int e;

  always #5 clk_i = ~clk_i;

  adc_sampler_model i_adc (
    .clk_i(clk_i),
    .ain_valid_o(ain_valid),
    .ain_present_o(ain_present),
    .ain_code_o(ain_code)
  );

  analog_setpoint_input_mapper #(
    .FAST_PERIOD(FP),
    .ADC_FULL(AF)
  ) i_dut (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .writedata_i(writedata_i),
    .byteenable_i(byteenable_i),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o),
    .factory_restore_i(factory_restore_i),
    .ain_valid_i(ain_valid),
    .ain_present_i(ain_present),
    .ain_code_i(ain_code),
    .fgen_iset_i(fgen_iset_i),
    .seq_setpt_i(seq_setpt_i),
    .vset_o(outs[0]),
    .iset_o(outs[1]),
    .pset_o(outs[2]),
    .overvoltage_trip_level_o(outs[3]),
    .overcurrent_trip_level_o(outs[4]),
    .overpower_trip_level_o(outs[5])
  );

  // ****************************************
  // Reference model and helpers
  // ****************************************
  // Saturating 0..full scale to 0..100 percent
  function automatic int spv(input int code, input logic pres);
    int c;
    c = pres ? code : 0;
    if (c > AF) begin
      c = AF;
    end
    return c * 40000 / AF;
  endfunction

  function automatic int src_exp(input int s, input int p);
    if (s == 1 && p == P_ISET) begin
      return fgen_iset_i;
    end
    if (s == 3 && p < 3) begin
      return seq_setpt_i[p*VAL_W +: VAL_W];
    end
    if (s == 2 && p == P_VSET) begin
      return spv(12'h800, 1'b1);
    end
    if (s == 2 && p == P_OV_TRIP) begin
      return PCT10;
    end
    return stored[p];
  endfunction

  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    read_i <= ~wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 50);
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (waitrequest_o !== 1'b0) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_ASSIGN, 32'h0);
    rdc(OFS_STORED0, 32'h0);
    rdc(8'h3C, 32'h0);
    for (int p = 0; p < 6; p++) begin
      stored[p] = $random(seed) & 32'hFFFF;
      bus(1'b1, 8'(OFS_STORED0 + 4 * p), stored[p]);
    end
    // Only lane 0 may change the stored word
    byteenable_i <= 4'h1;
    bus(1'b1, 8'(OFS_STORED0 + 4), 32'hFFFF_FFFF);
    byteenable_i <= 4'hF;
    stored[1] = (stored[1] & 32'hFF00) | 32'hFF;
    rdc(8'(OFS_STORED0 + 4), stored[1]);
    fgen_iset_i <= 16'($random(seed));
    seq_setpt_i <= 48'({$random(seed), $random(seed)});
    i_adc.sample(FAST_CH, 12'h800, 1'b1);
    // Unsampled channel 0 on the voltage trip gives the 10 percent floor
    bus(1'b1, OFS_ASSIGN, 32'h0000_0014);
    // Analog assignment must only matter under the analog source
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, OFS_CTRL, 32'(s));
      tick(FP + 4);
      for (int p = 0; p < 6; p++) begin
        chk({16'h0, outs[p]}, src_exp(s, p));
      end
    end
    bus(1'b1, OFS_CTRL, 32'h2);
    tick(4);
    rdc(OFS_STATUS, 32'h0000_0901);
    bus(1'b1, OFS_STORED0, 32'h0000_1234);
    tick(4);
    chk({16'h0, outs[0]}, spv(12'h800, 1'b1));
    rdc(OFS_STORED0, 32'h0000_1234);
    stored[0] = 32'h1234;
    // Every parameter code on the fast channel, boundary codes and a floating pin
    codes = '{12'h000, 12'hFFF, AF, 12'h5A5, 12'hABC};
    codes[3] = 12'($random(seed));
    for (int m = 1; m <= 6; m++) begin
      bus(1'b1, OFS_ASSIGN, 32'(m) << 4);
      for (int i = 0; i < 5; i++) begin
        i_adc.sample(FAST_CH, codes[i], i != 4);
        tick(FP + 4);
        e = spv(codes[i], i != 4) + (m > 3 ? 4000 : 0);
        chk({16'h0, outs[m-1]}, e);
        rdc(8'(OFS_EFF0 + 4 * (m - 1)), e);
      end
    end
    // Filtered channels; code 7 in the last field is not a parameter
    bus(1'b1, OFS_ASSIGN, 32'h0000_7502);
    rdc(OFS_ASSIGN, 32'h0000_0502);
    acc = '{0, 0, 0, 0};
    for (int n = 0; n < 12; n++) begin
      for (int c = 0; c < 4; c += 2) begin
        x = $random(seed) & 32'hFFF;
        i_adc.sample(c, x[ADC_W-1:0], 1'b1);
        acc[c] = acc[c] + x - (acc[c] >> 6);
      end
    end
    tick(4);
    chk({16'h0, outs[1]}, spv(acc[0] >> 6, 1'b1));
    chk({16'h0, outs[4]}, spv(acc[2] >> 6, 1'b1) + 4000);
    // Two channels on the set point; channel 0 wins and saturates
    bus(1'b1, OFS_ASSIGN, 32'h0000_0011);
    for (int n = 0; n < 200; n++) begin
      i_adc.sample(0, 12'hFFF, 1'b1);
      acc[0] = acc[0] + 4095 - (acc[0] >> 6);
    end
    tick(4);
    chk({16'h0, outs[0]}, spv(acc[0] >> 6, 1'b1));
    factory_restore_i <= 1'b1;
    @(posedge clk_i);
    factory_restore_i <= 1'b0;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_ASSIGN, 32'h0);
    tick(3);
    for (int p = 0; p < 6; p++) begin
      chk({16'h0, outs[p]}, stored[p]);
    end
    stop_test();
  end
endmodule
